// file: rtl/sms_socket_regs.sv
`timescale 1ns/10ps
`include "sms_consts.svh"

// Notes on behaviour
// - Events latch regardless of mask; mask only gates the interrupt.
// - Mask bit 3 lets power-cycle events interrupt when 1; default 0.
// - Detect field bits 2-1: 11 enables, 00 disables; 01/10 forbidden.
// - Mask bit 0 lets card-status events interrupt when 1; default 0.
// - Mask bits 31-4 read zero, ignore writes; mask resets to zero.
// - Forced writes show up in current-state bits beside live status.
// - Card voltage and type bits update only on insertion or a forced write.
// - Detect bits hold while interrogation uses the detect inputs.
// - Socket bits 31 and 30 read zero.
// - Socket bits 29 and 28 read one.
// - State bits 27-14 read zero; the state register is read-only.
// - State bits 13-10 show card support for the four supplies.
// - Bit 9 shows an invalid supply request; default zero.
// - Bit 8 flags possible data loss on removal; default zero.
// - Bit 7 flags unknown card; cleared by a valid insertion or a forced write with bit 7 low.
// - State register at 08h, resets to 3000 00XXh with live bits.
// - Events set on level change; CardBus status only on rising edge.
// - Detect bit reads 0 for low input, 1 for high input.
// - Forced test bit requests re-interrogation and state refresh.
module sms_socket_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register port
    input wire logic reg_valid,
    input wire logic reg_write,
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    // Socket pins
    input wire sms_pkg::sms_pins_type pins,
    // Interrogation logic
    input wire logic interrog_busy,
    input wire logic interrog_done,
    input wire sms_pkg::sms_card_info_type interrog_info,
    input wire logic interrog_unrecognized,
    output logic reinterrogate_trigger,
    // Socket control and data path flags
    input wire logic invalid_supply_set,
    input wire logic removal_loss_set,
    // Force-event register write
    input wire logic force_wr,
    input wire logic [31:0] force_data,
    // Status
    output logic [`SMS_EV_W-1:0] event_bits,
    output logic status_change_irq
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        hit = (a == o);
    endfunction : hit

    logic wr_mask;
    logic wr_event;
    assign wr_mask = reg_valid & reg_write & hit(reg_addr, `SMS_OFF_MASK);
    assign wr_event = reg_valid & reg_write & hit(reg_addr, `SMS_OFF_EVENT);

    // ------------------------------------------------------------------
    // Interrupt mask
    // ------------------------------------------------------------------
    logic power_cycle_irq_enable;
    logic [1:0] card_detect_irq_enable;
    logic card_status_irq_enable;

    always_ff @(posedge clock) begin
        if (srst) begin
            {power_cycle_irq_enable, card_detect_irq_enable,
                card_status_irq_enable} <= `SMS_MASK_RESET;
        end else if (wr_mask) begin
            power_cycle_irq_enable <= reg_wdata[`SMS_EV_PWR];
            card_detect_irq_enable <=
                reg_wdata[`SMS_EV_CD_HI:`SMS_EV_CD_LO];
            card_status_irq_enable <= reg_wdata[`SMS_EV_CS];
        end
    end

    // ------------------------------------------------------------------
    // Live and held state bits
    // ------------------------------------------------------------------
    logic primed;
    logic detect_one_level;
    logic detect_two_level;
    logic invalid_supply_request;
    logic removal_data_loss;
    logic unrecognized_card;
    sms_pkg::sms_card_info_type card_info;

    always_ff @(posedge clock) begin
        if (srst) begin
            primed <= 1'b0;
        end else begin
            primed <= 1'b1;
        end
    end

    // Detect bits follow the pins except while interrogation toggles them.
    // During reset the pins pass through so the reset value is live.
    always_ff @(posedge clock) begin
        if (srst || !interrog_busy) begin
            detect_one_level <= pins.detect_one;
            detect_two_level <= pins.detect_two;
        end
    end

    // A hardware set in the cycle of a forced write wins, so that a fault
    // reported by the socket is never hidden by software.
    always_ff @(posedge clock) begin
        if (srst) begin
            invalid_supply_request <= 1'b0;
        end else if (invalid_supply_set) begin
            invalid_supply_request <= 1'b1;
        end else if (force_wr) begin
            invalid_supply_request <= force_data[`SMS_FC_BAD];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            removal_data_loss <= 1'b0;
        end else if (removal_loss_set) begin
            removal_data_loss <= 1'b1;
        end else if (force_wr) begin
            removal_data_loss <= force_data[`SMS_FC_LOST];
        end
    end

    sms_state_capture u_capture (
        .clock(clock),
        .srst(srst),
        .done(interrog_done),
        .info_in(interrog_info),
        .unrecognized_in(interrog_unrecognized),
        .force_wr(force_wr),
        .force_data(force_data),
        .info(card_info),
        .unrecognized_card(unrecognized_card)
    );

    // One-cycle request to the interrogation logic.
    always_ff @(posedge clock) begin
        if (srst) begin
            reinterrogate_trigger <= 1'b0;
        end else begin
            reinterrogate_trigger <= force_wr & force_data[`SMS_FC_TEST];
        end
    end

    logic [31:0] current_state;
    always_comb begin
        current_state = `SMS_WORD_ZERO;
        current_state[`SMS_ST_CAPS_HI:`SMS_ST_CAPS_LO] =
            `SMS_SOCKET_CAPS;
        current_state[`SMS_ST_VC_HI:`SMS_ST_VC_LO] = {card_info.yy_volt,
            card_info.xx_volt, card_info.three_volt,
            card_info.five_volt};
        current_state[`SMS_ST_BAD] = invalid_supply_request;
        current_state[`SMS_ST_LOST] = removal_data_loss;
        current_state[`SMS_ST_NOCARD] = unrecognized_card;
        current_state[`SMS_ST_READY] = pins.ready_irq;
        current_state[`SMS_ST_CB] = card_info.cardbus;
        current_state[`SMS_ST_16] = card_info.sixteen_bit;
        current_state[`SMS_ST_PWR] = pins.powered;
        current_state[`SMS_ST_CD2] = detect_two_level;
        current_state[`SMS_ST_CD1] = detect_one_level;
        current_state[`SMS_ST_CS] = pins.card_status;
    end

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    logic [`SMS_EV_W-1:0] clear_bits;
    logic [`SMS_EV_W-1:0] force_bits;
    assign clear_bits = wr_event ? reg_wdata[`SMS_EV_W-1:0] : `SMS_EV_ZERO;
    assign force_bits = force_wr ?
        force_data[`SMS_FC_EV_HI:`SMS_FC_EV_LO] : `SMS_EV_ZERO;

    sms_event_reg u_events (
        .clock(clock),
        .srst(srst),
        .primed(primed),
        .levels({pins.powered, detect_two_level, detect_one_level,
            pins.card_status}),
        .cardbus(card_info.cardbus),
        .clear_bits(clear_bits),
        .force_bits(force_bits),
        .events(event_bits)
    );

    // The reserved detect codes enable nothing; only 11 opens the gate.
    logic [`SMS_EV_W-1:0] enables;
    always_comb begin
        enables = `SMS_EV_ZERO;
        enables[`SMS_EV_PWR] = power_cycle_irq_enable;
        enables[`SMS_EV_CD_HI] =
            (card_detect_irq_enable == `SMS_CD_ON);
        enables[`SMS_EV_CD_LO] = (card_detect_irq_enable == `SMS_CD_ON);
        enables[`SMS_EV_CS] = card_status_irq_enable;
    end
    assign status_change_irq = |(event_bits & enables);

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------
    function automatic logic [`SMS_EV_W-1:0] enables_raw(input logic p,
        input logic [1:0] c, input logic s);
        enables_raw = {p, c, s};
    endfunction : enables_raw

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = `SMS_WORD_ZERO;
        case (reg_addr)
            `SMS_OFF_EVENT: next_rdata[`SMS_EV_W-1:0] = event_bits;
            `SMS_OFF_MASK: next_rdata[`SMS_EV_W-1:0] =
                enables_raw(power_cycle_irq_enable, card_detect_irq_enable,
                card_status_irq_enable);
            `SMS_OFF_STATE: next_rdata = current_state;
            default: next_rdata = `SMS_WORD_ZERO;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_ack <= 1'b0;
            reg_rdata <= `SMS_WORD_ZERO;
        end else begin
            reg_ack <= reg_valid;
            reg_rdata <= (reg_valid && !reg_write) ? next_rdata :
                `SMS_WORD_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_mask_gates_irq: assert property (@(posedge clock) disable iff (srst)
        (event_bits[`SMS_EV_CS] && !card_status_irq_enable &&
        !power_cycle_irq_enable && card_detect_irq_enable == 2'h0)
        |-> !status_change_irq)
        else $error("Masked event raised interrupt.");
    chk_event_kept_masked: assert property (@(posedge clock) disable iff (srst)
        (primed && !card_info.cardbus && !wr_event &&
        $changed(pins.card_status)) |=> event_bits[`SMS_EV_CS])
        else $error("Status edge not latched.");
    chk_power_irq: assert property (@(posedge clock) disable iff (srst)
        (event_bits[`SMS_EV_PWR] && power_cycle_irq_enable)
        |-> status_change_irq)
        else $error("Power event did not interrupt.");
    chk_detect_reserved: assert property (@(posedge clock) disable iff (srst)
        (card_detect_irq_enable != `SMS_CD_ON && !event_bits[`SMS_EV_PWR] &&
        !event_bits[`SMS_EV_CS]) |-> !status_change_irq)
        else $error("Detect field other than 11 raised interrupt.");
    chk_mask_readback: assert property (@(posedge clock) disable iff (srst)
        (reg_valid && !reg_write && reg_addr == `SMS_OFF_MASK) |=>
        (reg_ack && reg_rdata[31:`SMS_EV_W] == 28'h0))
        else $error("Mask upper bits not zero.");
    chk_detect_hold: assert property (@(posedge clock) disable iff (srst)
        (primed && interrog_busy) |=> $stable(detect_one_level) &&
        $stable(detect_two_level))
        else $error("Detect bit moved during interrogation.");
    chk_caps_fixed: assert property (@(posedge clock) disable iff (srst)
        current_state[`SMS_ST_CAPS_HI:`SMS_ST_CAPS_LO] == 4'h3 &&
        current_state[`SMS_ST_RSVD_HI:`SMS_ST_RSVD_LO] == 14'h0)
        else $error("Fixed state bits wrong.");
    chk_card_hold: assert property (@(posedge clock) disable iff (srst)
        (!interrog_done && !force_wr) |=> $stable(card_info))
        else $error("Card facts changed without insertion.");
    chk_retest_pulse: assert property (@(posedge clock) disable iff (srst)
        (force_wr && force_data[`SMS_FC_TEST]) |=> reinterrogate_trigger
        ##1 !reinterrogate_trigger || $past(force_wr))
        else $error("Retest request missing.");
    chk_unknown_sticky: assert property (@(posedge clock) disable iff (srst)
        (unrecognized_card && !force_wr && !interrog_done)
        |=> unrecognized_card)
        else $error("Unknown-card flag dropped.");
    chk_cb_rising_only: assert property (@(posedge clock) disable iff (srst)
        (primed && card_info.cardbus && $fell(pins.card_status) &&
        !event_bits[`SMS_EV_CS] && !force_wr) |=>
        !event_bits[`SMS_EV_CS])
        else $error("CardBus falling edge set event.");
    chk_flags_forced: assert property (@(posedge clock) disable iff (srst)
        force_wr |=> (invalid_supply_request ==
        ($past(force_data[`SMS_FC_BAD]) | $past(invalid_supply_set)) &&
        removal_data_loss ==
        ($past(force_data[`SMS_FC_LOST]) | $past(removal_loss_set))))
        else $error("Forced flags not shown.");

    cov_irq_on: cover property (@(posedge clock) disable iff (srst)
        $rose(status_change_irq));
    cov_clear_event: cover property (@(posedge clock) disable iff (srst)
        wr_event && |event_bits ##1 !(|event_bits));
    cov_insertion: cover property (@(posedge clock) disable iff (srst)
        interrog_busy ##[1:20] interrog_done);
    cov_retest: cover property (@(posedge clock) disable iff (srst)
        reinterrogate_trigger);

endmodule : sms_socket_regs

// file: rtl/sms_consts.svh
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets within the socket window
// ----------------------------------------------------------------------
`define SMS_OFF_EVENT 6'h00
`define SMS_OFF_MASK 6'h04
`define SMS_OFF_STATE 6'h08

// ----------------------------------------------------------------------
// Event and mask field positions
// ----------------------------------------------------------------------
`define SMS_EV_PWR 3
`define SMS_EV_CD_HI 2
`define SMS_EV_CD_LO 1
`define SMS_EV_CS 0
`define SMS_EV_W 4
`define SMS_EV_ZERO 4'h0
`define SMS_CD_ON 2'h3

// ----------------------------------------------------------------------
// Current-state field positions and values
// ----------------------------------------------------------------------
`define SMS_ST_CAPS_HI 31
`define SMS_ST_CAPS_LO 28
`define SMS_ST_RSVD_HI 27
`define SMS_ST_RSVD_LO 14
`define SMS_ST_RSVD_W 14
`define SMS_ST_VC_HI 13
`define SMS_ST_VC_LO 10
`define SMS_ST_BAD 9
`define SMS_ST_LOST 8
`define SMS_ST_NOCARD 7
`define SMS_ST_READY 6
`define SMS_ST_CB 5
`define SMS_ST_16 4
`define SMS_ST_PWR 3
`define SMS_ST_CD2 2
`define SMS_ST_CD1 1
`define SMS_ST_CS 0
// Socket supplies 3.3 V and 5 V only; the two unnamed supplies read 0.
`define SMS_SOCKET_CAPS 4'h3
`define SMS_MASK_RESET 4'h0
`define SMS_WORD_ZERO 32'h0000_0000

// ----------------------------------------------------------------------
// Force-write field positions
// ----------------------------------------------------------------------
`define SMS_FC_TEST 14
`define SMS_FC_VC_HI 13
`define SMS_FC_VC_LO 10
`define SMS_FC_BAD 9
`define SMS_FC_LOST 8
`define SMS_FC_NOCARD 7
`define SMS_FC_CB 5
`define SMS_FC_16 4
`define SMS_FC_EV_HI 3
`define SMS_FC_EV_LO 0

`endif

// file: rtl/sms_pkg.sv
package sms_pkg;

    // Card facts learned by interrogation, held until the next interrogation or forced write.
    typedef struct packed {
        logic yy_volt;
        logic xx_volt;
        logic three_volt;
        logic five_volt;
        logic cardbus;
        logic sixteen_bit;
    } sms_card_info_type;

    // Live socket pin levels, sampled on the bus clock.
    typedef struct packed {
        logic detect_one;
        logic detect_two;
        logic card_status;
        logic ready_irq;
        logic powered;
    } sms_pins_type;

endpackage : sms_pkg

// file: rtl/sms_event_reg.sv
`timescale 1ns/10ps
`include "sms_consts.svh"

module sms_event_reg (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Level sources, bit order power, detect two, detect one, status
    input wire logic primed,
    input wire logic [`SMS_EV_W-1:0] levels,
    input wire logic cardbus,
    // Software set and clear
    input wire logic [`SMS_EV_W-1:0] clear_bits,
    input wire logic [`SMS_EV_W-1:0] force_bits,
    // Sticky flags
    output logic [`SMS_EV_W-1:0] events
);

    logic [`SMS_EV_W-1:0] prev;
    logic [`SMS_EV_W-1:0] change;

    // The first cycle after reset only records levels, so that reset
    // itself does not look like a change.
    always_ff @(posedge clock) begin
        if (srst) begin
            prev <= `SMS_EV_ZERO;
        end else begin
            prev <= levels;
        end
    end

    always_comb begin
        change = primed ? (levels ^ prev) : `SMS_EV_ZERO;
        if (cardbus) begin
            change[`SMS_EV_CS] = primed & levels[`SMS_EV_CS] &
                ~prev[`SMS_EV_CS];
        end
    end

    // A set in the cycle of a clear wins, so no event is lost.
    always_ff @(posedge clock) begin
        if (srst) begin
            events <= `SMS_EV_ZERO;
        end else begin
            events <= (events & ~clear_bits) | change | force_bits;
        end
    end

endmodule : sms_event_reg

// file: rtl/sms_state_capture.sv
`timescale 1ns/10ps
`include "sms_consts.svh"

module sms_state_capture (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Interrogation result
    input wire logic done,
    input wire sms_pkg::sms_card_info_type info_in,
    input wire logic unrecognized_in,
    // Force write
    input wire logic force_wr,
    input wire logic [31:0] force_data,
    // Held card facts
    output sms_pkg::sms_card_info_type info,
    output logic unrecognized_card
);

    // Card facts change only on an interrogation or a forced write.
    always_ff @(posedge clock) begin
        if (srst) begin
            info <= '0;
        end else if (force_wr) begin
            info.yy_volt <= force_data[`SMS_FC_VC_HI];
            info.xx_volt <= force_data[`SMS_FC_VC_HI-1];
            info.three_volt <= force_data[`SMS_FC_VC_LO+1];
            info.five_volt <= force_data[`SMS_FC_VC_LO];
            info.cardbus <= force_data[`SMS_FC_CB];
            info.sixteen_bit <= force_data[`SMS_FC_16];
        end else if (done) begin
            info <= info_in;
        end
    end

    // An unknown card sets the flag; only a valid card or a forced write with bit 7 low clears it again.
    always_ff @(posedge clock) begin
        if (srst) begin
            unrecognized_card <= 1'b0;
        end else if (force_wr) begin
            unrecognized_card <= force_data[`SMS_FC_NOCARD];
        end else if (done) begin
            unrecognized_card <= unrecognized_in;
        end
    end

endmodule : sms_state_capture

// file: rtl/sms_pkg_order_note.sv
`timescale 1ns/10ps

// file: bench/sms_card_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Socket side: detect pins, interrogation and card levels
// ----------------------------------------------------------------------
// Card facts are valid only with the done pulse. At other times the
// inverse is shown, so that a late sample reads a wrong value.
module sms_card_model (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Card levels set by the bench
    input wire logic insert,
    input wire logic cs_level,
    input wire logic rdy_level,
    input wire logic pwr_level,
    input wire sms_pkg::sms_card_info_type kind,
    input wire logic unknown,
    // Toward the design
    output sms_pkg::sms_pins_type pins,
    output logic busy,
    output logic done,
    output sms_pkg::sms_card_info_type info,
    output logic unrecognized
);
    logic was_in;
    logic [3:0] cnt;

    always_ff @(posedge clock) begin
        if (srst) begin
            was_in <= 1'b0;
            cnt <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            was_in <= insert;
            done <= busy && cnt == 4'h1;
            if (insert && !was_in) begin
                cnt <= 4'h8;
                busy <= 1'b1;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
                busy <= cnt != 4'h1;
            end
        end
    end

    // Interrogation wiggles the second detect line while it runs.
    assign pins = {!insert, busy ? cnt[0] : !was_in, cs_level, rdy_level,
        pwr_level};
    assign info = done ? kind : ~kind;
    assign unrecognized = done ? unknown : !unknown;
endmodule : sms_card_model

// file: bench/sms_socket_regs_test.sv
`timescale 1ns/10ps
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin \
    n_fail++; $display("wrong value at %0t: got %h want %h", \
    $time, g, w); end end

module sms_socket_regs_test;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic reg_valid = 1'b0;
    logic reg_write = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val, force_data = 32'h0;
    logic reg_ack, trig, irq, m_busy, m_done, m_unrec;
    logic ins = 0, cs = 0, rdy = 0, pwr = 0, unk = 0, force_wr = 0;
    logic bad_p = 0, lost_p = 0, bad = 0, lost = 0, nc = 0;
    logic [3:0] event_bits;
    sms_pkg::sms_card_info_type kind = '0, cinfo = '0, m_info;
    sms_pkg::sms_pins_type pins;
    int n_fail = 0;
    int samples_checked = 0;

    always #5 clock = ~clock;

    sms_card_model u_sms_card_model (.clock(clock), .srst(srst),
        .insert(ins), .cs_level(cs), .rdy_level(rdy), .pwr_level(pwr),
        .kind(kind), .unknown(unk), .pins(pins), .busy(m_busy),
        .done(m_done), .info(m_info), .unrecognized(m_unrec));

    sms_socket_regs u_sms_socket_regs (.clock(clock), .srst(srst),
        .reg_valid(reg_valid), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .pins(pins), .interrog_busy(m_busy), .interrog_done(m_done),
        .interrog_info(m_info), .interrog_unrecognized(m_unrec),
        .reinterrogate_trigger(trig), .invalid_supply_set(bad_p),
        .removal_loss_set(lost_p), .force_wr(force_wr),
        .force_data(force_data), .event_bits(event_bits),
        .status_change_irq(irq));

    function automatic logic [31:0] st;
        st = {4'h3, 14'h0, cinfo[5:2], bad, lost, nc, rdy, cinfo[1:0], pwr,
            !ins, !ins, cs};
    endfunction : st

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic acc(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        @(posedge clock);
        reg_valid <= 1'b1;
        reg_write <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_valid <= 1'b0;
        #1;
        rd_val = reg_rdata;
        `CHK(reg_ack, 1'b1)
    endtask : acc

    task automatic t_reset;
        acc(0, 6'h04, 0);
        `CHK(rd_val, 32'h0)
        acc(0, 6'h08, 0);
        `CHK(rd_val, st())
        `CHK(irq, 1'b0)
        $display("t_reset done");
    endtask : t_reset

    task automatic t_regs;
        @(posedge clock) rdy <= 1'b1;
        acc(1, 6'h04, 32'hffff_ffff);
        acc(0, 6'h04, 0);
        `CHK(rd_val, 32'h0000_000f)
        acc(1, 6'h04, 0);
        acc(1, 6'h08, 32'hffff_ffff);
        acc(0, 6'h08, 0);
        `CHK(rd_val, st())
        acc(0, 6'h3c, 0);
        `CHK(rd_val, 32'h0)
        $display("t_regs done");
    endtask : t_regs

    task automatic t_power;
        @(posedge clock) pwr <= 1'b1;
        tick(3);
        `CHK(event_bits, 4'h8)
        `CHK(irq, 1'b0)
        acc(1, 6'h04, 32'h8);
        `CHK(irq, 1'b1)
        acc(1, 6'h04, 32'h1);
        `CHK(irq, 1'b0)
        @(posedge clock) cs <= 1'b1;
        tick(3);
        `CHK(irq, 1'b1)
        acc(0, 6'h00, 0);
        `CHK(rd_val, 32'h9)
        acc(1, 6'h00, 32'hf);
        acc(1, 6'h04, 0);
        `CHK(event_bits, 4'h0)
        $display("t_power done");
    endtask : t_power

    task automatic t_insert(input sms_pkg::sms_card_info_type k,
        input logic u);
        @(posedge clock);
        ins <= 1'b1;
        kind <= k;
        unk <= u;
        tick(5);
        acc(0, 6'h08, 0);
        `CHK(rd_val[2], 1'b1)
        repeat (20) if (m_done !== 1'b1) tick(1);
        tick(2);
        cinfo = k;
        nc = u;
        acc(0, 6'h08, 0);
        `CHK(rd_val, st())
        `CHK(event_bits[2:1], 2'h3)
        acc(1, 6'h04, 32'h6);
        `CHK(irq, 1'b1)
        acc(1, 6'h04, 0);
        `CHK(irq, 1'b0)
        acc(1, 6'h00, 32'hf);
        $display("t_insert done");
    endtask : t_insert

    task automatic t_cs;
        @(posedge clock) cs <= ~cs;
        tick(3);
        `CHK(event_bits[0], !cinfo[1] | cs)
        acc(1, 6'h00, 32'hf);
        $display("t_cs done");
    endtask : t_cs

    task automatic t_remove;
        @(posedge clock) ins <= 1'b0;
        tick(12);
        acc(0, 6'h08, 0);
        `CHK(rd_val[7], nc)
        acc(1, 6'h00, 32'hf);
        $display("t_remove done");
    endtask : t_remove

    task automatic t_force;
        @(posedge clock);
        bad_p <= 1'b1;
        lost_p <= 1'b1;
        @(posedge clock);
        bad_p <= 1'b0;
        lost_p <= 1'b0;
        tick(2);
        bad = 1'b1;
        lost = 1'b1;
        acc(0, 6'h08, 0);
        `CHK(rd_val, st())
        @(posedge clock);
        force_wr <= 1'b1;
        force_data <= 32'h0000_6a95;
        @(posedge clock) force_wr <= 1'b0;
        #1;
        `CHK(trig, 1'b1)
        tick(1);
        `CHK(trig, 1'b0)
        cinfo = 6'b101001;
        lost = 1'b0;
        nc = 1'b1;
        acc(0, 6'h08, 0);
        `CHK(rd_val, st())
        `CHK(event_bits, 4'h5)
        $display("t_force done");
    endtask : t_force

    task automatic results;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #100000;
        n_fail++;
        results();
    end

    initial begin
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_regs();
        t_power();
        t_insert(6'b001110, 1'b0);
        t_cs();
        t_cs();
        t_remove();
        t_insert(6'b000001, 1'b1);
        t_remove();
        t_insert(6'b000101, 1'b0);
        t_cs();
        t_cs();
        t_force();
        results();
    end
endmodule : sms_socket_regs_test
